/* File: rtl/periph_irq_pkg.sv */
`default_nettype none
package periph_irq_pkg;
  // bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / 8;
  localparam int REG_W = 8;

  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] ENABLE_OFF = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] FLAG_OFF = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFF = 8'h08;

  // enable and flag bit positions, same layout in both registers
  localparam int CONVERTER_BIT = 6;
  localparam int CAPTURE_COMPARE_BIT = 5;
  localparam int COMPARATOR_BIT = 3;
  localparam int TIMER2_MATCH_BIT = 1;
  localparam int TIMER1_OVERFLOW_BIT = 0;

  // core interrupt control bit positions
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int GROUP_ENABLE_BIT = 6;

  // implemented bit masks per device variant, then the reserved and reduced-only bit masks
  localparam logic [REG_W-1:0] FULL_IMPL_MASK = 8'h6b;
  localparam logic [REG_W-1:0] REDUCED_IMPL_MASK = 8'h09;
  localparam logic [REG_W-1:0] RESERVED_MASK = 8'h94;
  localparam logic [REG_W-1:0] REDUCED_ONLY_MASK = 8'h62;

  // reset values
  localparam logic [REG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [REG_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [AXI_DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: rtl/sticky_flag_cell.sv */
`default_nettype none
module sticky_flag_cell #(
  parameter bit IMPLEMENTED = 1'b1
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // set by event, cleared by software
  input wire logic set_in,
  input wire logic clr_in,
  // stored flag
  output logic flag_out
);
  logic flag_q;
  logic flag_d;

  // set wins over a clear in the same cycle
  assign flag_d = IMPLEMENTED & ((flag_q & ~clr_in) | set_in);
  assign flag_out = flag_q;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/peripheral_interrupt_enable_reg.sv */
// Added by the designer: the register offsets and register access over AXI4-Lite.
`default_nettype none
// Functional notes
// R1 - no peripheral request reaches the core while the group enable is clear
// R2 - bit 6 is the read/write converter interrupt enable
// R3 - bit 5 is the read/write capture/compare interrupt enable
// R4 - bit 3 is the read/write comparator interrupt enable
// R5 - bit 1 is the read/write timer2 period match interrupt enable
// R6 - bit 0 is the read/write timer1 overflow interrupt enable
// R7 - bits 7, 4 and 2 read zero and ignore writes
// R8 - reduced variant: bits 6, 5 and 1 read zero and do nothing
// R9 - nothing reaches the core while the global enable is clear
// R10 - flags set on their event regardless of any enable
// R11 - request is OR of flag AND enable, gated by group and global
// R12 - all enables reset to zero
module peripheral_interrupt_enable_reg #(
  parameter bit FULL_FEATURE = 1'b1
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // axi4-lite write address
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [periph_irq_pkg::AXI_ADDR_W-1:0] awaddr_in,
  // axi4-lite write data
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [periph_irq_pkg::AXI_DATA_W-1:0] wdata_in,
  input wire logic [periph_irq_pkg::AXI_STRB_W-1:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read address
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [periph_irq_pkg::AXI_ADDR_W-1:0] araddr_in,
  // axi4-lite read data
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [periph_irq_pkg::AXI_DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  // peripheral events, one-cycle pulses
  input wire logic converter_done_in,
  input wire logic capture_compare_in,
  input wire logic comparator_change_in,
  input wire logic timer2_match_in,
  input wire logic timer1_overflow_in,
  // request to the core
  output logic irq_out
);
  import periph_irq_pkg::*;

  localparam logic [REG_W-1:0] IMPL_MASK = FULL_FEATURE ? FULL_IMPL_MASK : REDUCED_IMPL_MASK;

  // write channel state
  logic awready_q, awready_d;
  logic aw_hold_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic wready_q, wready_d;
  logic w_hold_q;
  logic [REG_W-1:0] w_data_q;
  logic w_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  // read channel state
  logic arready_q, arready_d;
  logic rvalid_q;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  // block state
  logic [REG_W-1:0] enable_q, enable_d;
  logic global_q, global_d;
  logic group_q, group_d;
  logic irq_q, irq_d;

  wire aw_take = awvalid_in & awready_q;
  wire w_take = wvalid_in & wready_q;
  wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  wire ar_take = arvalid_in & arready_q;

  assign awready_d = awvalid_in & ~awready_q & ~aw_hold_q & ~bvalid_q;
  assign wready_d = wvalid_in & ~wready_q & ~w_hold_q & ~bvalid_q;
  assign arready_d = arvalid_in & ~arready_q & ~rvalid_q;

  // write decode
  wire wr_sel_enable = aw_addr_q[AXI_ADDR_W-1:2] == ENABLE_OFF[AXI_ADDR_W-1:2];
  wire wr_sel_flag = aw_addr_q[AXI_ADDR_W-1:2] == FLAG_OFF[AXI_ADDR_W-1:2];
  wire wr_sel_ctrl = aw_addr_q[AXI_ADDR_W-1:2] == CTRL_OFF[AXI_ADDR_W-1:2];
  wire wr_mapped = wr_sel_enable | wr_sel_flag | wr_sel_ctrl;
  wire wr_enable = do_write & wr_sel_enable & w_strb0_q;
  wire wr_flag = do_write & wr_sel_flag & w_strb0_q;
  wire wr_ctrl = do_write & wr_sel_ctrl & w_strb0_q;

  // unimplemented bits are masked off on every write
  assign enable_d = wr_enable ? (w_data_q & IMPL_MASK) : enable_q; // see R2 R3 R4 R5 R6 R7 R8
  assign global_d = wr_ctrl ? w_data_q[GLOBAL_ENABLE_BIT] : global_q;
  assign group_d = wr_ctrl ? w_data_q[GROUP_ENABLE_BIT] : group_q;

  // event vector in the flag layout
  logic [REG_W-1:0] event_vec;
  always_comb begin
    event_vec = '0;
    event_vec[CONVERTER_BIT] = converter_done_in;
    event_vec[CAPTURE_COMPARE_BIT] = capture_compare_in;
    event_vec[COMPARATOR_BIT] = comparator_change_in;
    event_vec[TIMER2_MATCH_BIT] = timer2_match_in;
    event_vec[TIMER1_OVERFLOW_BIT] = timer1_overflow_in;
  end

  wire [REG_W-1:0] flag_clr = {REG_W{wr_flag}} & w_data_q;
  logic [REG_W-1:0] flag_vec;

  // flags ignore every enable; write one to clear
  for (genvar i = 0; i < REG_W; i++) begin : g_flag
    sticky_flag_cell #(
      .IMPLEMENTED(IMPL_MASK[i])
    ) u_flag (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .set_in(event_vec[i]), // see R10
      .clr_in(flag_clr[i]),
      .flag_out(flag_vec[i])
    );
  end

  // request combine and gating
  wire periph_pending = |(flag_vec & enable_q); // see R11
  assign irq_d = global_q & group_q & periph_pending; // see R1 R9 R11

  // read decode
  wire rd_sel_enable = araddr_in[AXI_ADDR_W-1:2] == ENABLE_OFF[AXI_ADDR_W-1:2];
  wire rd_sel_flag = araddr_in[AXI_ADDR_W-1:2] == FLAG_OFF[AXI_ADDR_W-1:2];
  wire rd_sel_ctrl = araddr_in[AXI_ADDR_W-1:2] == CTRL_OFF[AXI_ADDR_W-1:2];
  wire rd_mapped = rd_sel_enable | rd_sel_flag | rd_sel_ctrl;
  wire [REG_W-1:0] ctrl_vec = {global_q, group_q, 6'h00};
  wire [REG_W-1:0] rd_byte = rd_sel_enable ? enable_q :
                             rd_sel_flag ? flag_vec :
                             rd_sel_ctrl ? ctrl_vec : 8'h00;
  wire [AXI_DATA_W-1:0] rd_word = {24'h00_0000, rd_byte};

  // write address and data capture
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      awready_q <= awready_d;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr_in;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
    end else begin
      wready_q <= wready_d;
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata_in[REG_W-1:0];
        w_strb0_q <= wstrb_in[0];
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q & bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= RDATA_RESET;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q & rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // block registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      enable_q <= ENABLE_RESET; // see R12
      global_q <= CTRL_RESET[GLOBAL_ENABLE_BIT];
      group_q <= CTRL_RESET[GROUP_ENABLE_BIT];
      irq_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      global_q <= global_d;
      group_q <= group_d;
      irq_q <= irq_d;
    end
  end

  assign awready_out = awready_q;
  assign wready_out = wready_q;
  assign bvalid_out = bvalid_q;
  assign bresp_out = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out = rvalid_q;
  assign rdata_out = rdata_q;
  assign rresp_out = rresp_q;
  assign irq_out = irq_q;

  // checks
  sequence enable_write_s;
    wr_enable;
  endsequence

  sequence read_accept_s;
    arvalid_in && arready_q;
  endsequence

  property enable_written_p;
    @(posedge mclk_in) disable iff (sys_rst_in)
      enable_write_s |=> (enable_q == ($past(w_data_q) & IMPL_MASK));
  endproperty

  enable_store_a: assert property (enable_written_p) else $error("enable bits not stored"); // see R2

  group_block_a: assert property ( // see R1
    @(posedge mclk_in) disable iff (sys_rst_in) !group_q |=> !irq_q)
    else $error("request passed with group enable clear");

  global_block_a: assert property ( // see R9
    @(posedge mclk_in) disable iff (sys_rst_in) !global_q |=> !irq_q)
    else $error("request passed with global enable clear");

  request_combine_a: assert property ( // see R11
    @(posedge mclk_in) disable iff (sys_rst_in)
      irq_q == $past(global_q && group_q && ((flag_vec & enable_q) != 8'h00)))
    else $error("request does not match flags and enables");

  enable_hold_a: assert property ( // see R3
    @(posedge mclk_in) disable iff (sys_rst_in)
      enable_write_s ##1 (!wr_enable)[*2] |-> enable_q == $past(enable_q))
    else $error("enable bits changed without a write");

  reserved_zero_a: assert property ( // see R7
    @(posedge mclk_in) disable iff (sys_rst_in)
      read_accept_s and rd_sel_enable |=> (rdata_q[7:0] & RESERVED_MASK) == 8'h00)
    else $error("reserved enable bit read as one");

  variant_zero_a: assert property ( // see R8
    @(posedge mclk_in) disable iff (sys_rst_in)
      !FULL_FEATURE |-> ((enable_q | flag_vec) & REDUCED_ONLY_MASK) == 8'h00)
    else $error("reduced variant bit is set");

  flag_independent_a: assert property ( // see R10
    @(posedge mclk_in) disable iff (sys_rst_in)
      (event_vec & IMPL_MASK) != 8'h00 |=> (flag_vec & $past(event_vec & IMPL_MASK))
        == $past(event_vec & IMPL_MASK))
    else $error("event did not set its flag");

  reset_clear_a: assert property ( // see R12
    @(posedge mclk_in) disable iff (sys_rst_in)
      $fell(sys_rst_in) |-> enable_q == 8'h00 && !irq_q && flag_vec == 8'h00)
    else $error("enables not zero after reset");

  enable_read_a: assert property ( // see R4 R5 R6
    @(posedge mclk_in) disable iff (sys_rst_in)
      read_accept_s and rd_sel_enable |=> rdata_q == {24'h00_0000, $past(enable_q)})
    else $error("enable read back wrong");

  write_answer_a: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in) do_write |=> bvalid_q ##0 !aw_hold_q)
    else $error("write response missing");

  read_hold_a: assert property (
    @(posedge mclk_in) disable iff (sys_rst_in)
      rvalid_q && !rready_in |=> rvalid_q && $stable(rdata_q))
    else $error("read data dropped before rready");
endmodule
`default_nettype wire

/* File: verification/peripheral_interrupt_enable_reg_tb.sv */
`default_nettype none
module peripheral_interrupt_enable_reg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import periph_irq_pkg::*;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  // response channels always accept, so no ready is dropped and raised in one step
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b1;
  logic arvalid_in = 1'b0, rready_in = 1'b1;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00, evt = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic [3:0] wstrb_in = 4'h1;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out, r_irq;
  logic [1:0] bresp_out, rresp_out;
  logic [31:0] rdata_out, r_rdata;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // full variant drives the bus handshakes; reduced variant shares all inputs
  peripheral_interrupt_enable_reg #(.FULL_FEATURE(1'b1)) u_peripheral_interrupt_enable_reg (
    .mclk_in, .sys_rst_in, .awvalid_in, .awready_out, .awaddr_in, .wvalid_in,
    .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in, .bresp_out,
    .arvalid_in, .arready_out, .araddr_in, .rvalid_out, .rready_in, .rdata_out,
    .rresp_out, .converter_done_in(evt[CONVERTER_BIT]),
    .capture_compare_in(evt[CAPTURE_COMPARE_BIT]),
    .comparator_change_in(evt[COMPARATOR_BIT]), .timer2_match_in(evt[TIMER2_MATCH_BIT]),
    .timer1_overflow_in(evt[TIMER1_OVERFLOW_BIT]), .irq_out);
  peripheral_interrupt_enable_reg #(.FULL_FEATURE(1'b0)) u_peripheral_interrupt_enable_reg_red (
    .mclk_in, .sys_rst_in, .awvalid_in, .awready_out(), .awaddr_in, .wvalid_in,
    .wready_out(), .wdata_in, .wstrb_in, .bvalid_out(), .bready_in, .bresp_out(),
    .arvalid_in, .arready_out(), .araddr_in, .rvalid_out(), .rready_in,
    .rdata_out(r_rdata), .rresp_out(), .converter_done_in(evt[CONVERTER_BIT]),
    .capture_compare_in(evt[CAPTURE_COMPARE_BIT]),
    .comparator_change_in(evt[COMPARATOR_BIT]), .timer2_match_in(evt[TIMER2_MATCH_BIT]),
    .timer1_overflow_in(evt[TIMER1_OVERFLOW_BIT]), .irq_out(r_irq));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, d, input logic [1:0] rs);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr_in <= a;
    wdata_in <= {24'h0, d};
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge mclk_in);
      if (awvalid_in && awready_out) begin
        ad = 1'b1;
        awvalid_in <= 1'b0;
      end
      if (wvalid_in && wready_out) begin
        dd = 1'b1;
        wvalid_in <= 1'b0;
      end
    end
    do @(posedge mclk_in); while (!bvalid_out);
    check("bresp", {30'h0, bresp_out}, {30'h0, rs});
  endtask

  task automatic rd(input logic [7:0] a, ef, er, input logic [1:0] rs);
    araddr_in <= a;
    arvalid_in <= 1'b1;
    do @(posedge mclk_in); while (!arready_out);
    arvalid_in <= 1'b0;
    do @(posedge mclk_in); while (!rvalid_out);
    check("rdata full", rdata_out, {24'h0, ef});
    check("rdata reduced", r_rdata, {24'h0, er});
    check("rresp", {30'h0, rresp_out}, {30'h0, rs});
  endtask

  task automatic pulse(input logic [7:0] m);
    evt <= m;
    @(posedge mclk_in);
    evt <= 8'h00;
  endtask

  task automatic chk_irq(input logic ef, er);
    repeat (3) @(posedge mclk_in);
    check("irq full", {31'h0, irq_out}, {31'h0, ef});
    check("irq reduced", {31'h0, r_irq}, {31'h0, er});
  endtask

  task automatic reset_values;
    rd(ENABLE_OFF, 8'h00, 8'h00, RESP_OKAY);
    rd(FLAG_OFF, 8'h00, 8'h00, RESP_OKAY);
    rd(CTRL_OFF, 8'h00, 8'h00, RESP_OKAY);
    chk_irq(1'b0, 1'b0);
  endtask

  task automatic enable_rw;
    wr(ENABLE_OFF, 8'hff, RESP_OKAY);
    rd(ENABLE_OFF, FULL_IMPL_MASK, REDUCED_IMPL_MASK, RESP_OKAY);
    wr(ENABLE_OFF, RESERVED_MASK, RESP_OKAY);
    rd(ENABLE_OFF, 8'h00, 8'h00, RESP_OKAY);
    wr(CTRL_OFF, 8'hff, RESP_OKAY);
    rd(CTRL_OFF, 8'hc0, 8'hc0, RESP_OKAY);
  endtask

  task automatic gating;
    wr(CTRL_OFF, 8'h00, RESP_OKAY);
    wr(ENABLE_OFF, 8'hff, RESP_OKAY);
    pulse(8'h01);
    chk_irq(1'b0, 1'b0);
    rd(FLAG_OFF, 8'h01, 8'h01, RESP_OKAY);
    wr(CTRL_OFF, 8'h40, RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    wr(CTRL_OFF, 8'h80, RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    wr(CTRL_OFF, 8'hc0, RESP_OKAY);
    chk_irq(1'b1, 1'b1);
    wr(ENABLE_OFF, 8'hfe, RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    wr(FLAG_OFF, 8'h01, RESP_OKAY);
    rd(FLAG_OFF, 8'h00, 8'h00, RESP_OKAY);
  endtask

  // each position alone: blocked by the other enables, passed by its own where implemented
  task automatic sources;
    logic [7:0] m;
    wr(CTRL_OFF, 8'hc0, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(ENABLE_OFF, ~m, RESP_OKAY);
      pulse(m);
      chk_irq(1'b0, 1'b0);
      rd(FLAG_OFF, m & FULL_IMPL_MASK, m & REDUCED_IMPL_MASK, RESP_OKAY);
      wr(ENABLE_OFF, m, RESP_OKAY);
      chk_irq(|(m & FULL_IMPL_MASK), |(m & REDUCED_IMPL_MASK));
      wr(FLAG_OFF, m, RESP_OKAY);
      chk_irq(1'b0, 1'b0);
    end
  endtask

  task automatic unmapped;
    wr(8'h0c, 8'hff, RESP_SLVERR);
    rd(8'h0c, 8'h00, 8'h00, RESP_SLVERR);
    // lane 0 strobe low: answered but not stored
    wstrb_in <= 4'h0;
    wr(ENABLE_OFF, 8'hff, RESP_OKAY);
    wstrb_in <= 4'h1;
    rd(ENABLE_OFF, 8'h00, 8'h00, RESP_OKAY);
  endtask

  task automatic mid_reset;
    wr(ENABLE_OFF, 8'hff, RESP_OKAY);
    pulse(8'h08);
    chk_irq(1'b1, 1'b1);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    check("irq after reset", {31'h0, irq_out}, 32'h0);
    rd(FLAG_OFF, 8'h00, 8'h00, RESP_OKAY);
    rd(ENABLE_OFF, 8'h00, 8'h00, RESP_OKAY);
    rd(CTRL_OFF, 8'h00, 8'h00, RESP_OKAY);
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    reset_values;
    enable_rw;
    gating;
    sources;
    unmapped;
    mid_reset;
    wrap_up;
  end
endmodule
`default_nettype wire
